// file: tdpwm_pkg.sv
package tdpwm_pkg;
    // Register byte offsets (word aligned)
    localparam logic [7:0] TDPWM_OFS_PERIOD = 8'h00;
    localparam logic [7:0] TDPWM_OFS_TCTRL = 8'h04;
    localparam logic [7:0] TDPWM_OFS_COUNT = 8'h08;
    localparam logic [7:0] TDPWM_OFS_MOD_BASE = 8'h10;
    localparam logic [7:0] TDPWM_OFS_MOD_STRIDE = 8'h10;
    localparam logic [7:0] TDPWM_OFS_CTRL = 8'h00;
    localparam logic [7:0] TDPWM_OFS_DUTY_HI = 8'h04;
    localparam logic [7:0] TDPWM_OFS_DUTY_LO = 8'h08;
    // Field positions
    localparam int TDPWM_CTRL_POL = 4;
    localparam int TDPWM_CTRL_OE = 6;
    localparam int TDPWM_CTRL_EN = 7;
    localparam int TDPWM_TCTRL_ON = 2;
    localparam int TDPWM_DLO_LSB = 6;
    // Sizes and reset values
    localparam int TDPWM_NUM_MOD = 4;
    localparam int TDPWM_DUTY_W = 10;
    localparam logic [7:0] TDPWM_PERIOD_RST = 8'hFF;
    localparam logic [7:0] TDPWM_BYTE_RST = 8'h00;
    // One oscillator period per system clock; four of them make one timer tick at 1:1
    localparam logic [1:0] TDPWM_QUARTER_LAST = 2'h3;
    localparam logic [1:0] TDPWM_PRE_1 = 2'h0;
    localparam logic [1:0] TDPWM_PRE_4 = 2'h1;
    localparam logic [1:0] TDPWM_PRE_16 = 2'h2;
    localparam logic [1:0] TDPWM_PRE_64 = 2'h3;
    localparam logic [1:0] TDPWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] TDPWM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TDPWM_BUS_IDLE = 2'b00,
        TDPWM_BUS_RESP = 2'b01
    } tdpwm_bus_t;
endpackage : tdpwm_pkg

// file: tdpwm_prescaler.sv
`timescale 1ns/1ps
module tdpwm_prescaler
    import tdpwm_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] ratio,
    // Tick to time base
    output logic tick
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] last;
    logic hit;

    function automatic logic [5:0] ratio_last(input logic [1:0] r);
        case (r)
            TDPWM_PRE_1: ratio_last = 6'h00;
            TDPWM_PRE_4: ratio_last = 6'h03;
            TDPWM_PRE_16: ratio_last = 6'h0F;
            TDPWM_PRE_64: ratio_last = 6'h3F;
            default: ratio_last = 6'h00;
        endcase
    endfunction : ratio_last

    // Only the prescaler scales timing; no postscaler exists in this path
    assign last = ratio_last(ratio);
    assign hit = run && (cnt_r >= last);
    assign tick = hit;
    assign cnt_nxt = (!run || hit) ? 6'h00 : cnt_r + 6'h01;

    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_r <= 6'h00;
        else if (ce)
            cnt_r <= cnt_nxt;
    end
endmodule : tdpwm_prescaler

// file: tdpwm_channel.sv
`timescale 1ns/1ps
module tdpwm_channel
    import tdpwm_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic enable,
    input wire logic polarity,
    input wire logic period_start,
    input wire logic reload,
    // Time base and duty
    input wire logic [9:0] time_base,
    input wire logic [7:0] period_value,
    input wire logic [7:0] duty_hi,
    input wire logic [7:0] duty_lo,
    // Compare result after polarity
    output logic level
);
    logic [9:0] duty_buf_r;
    logic [9:0] duty_nxt;
    logic raw_r;
    logic raw_nxt;
    logic full_on;

    // Upper eight from high register, two from low register bits 7:6
    assign duty_nxt = reload ? {duty_hi, duty_lo[TDPWM_DLO_LSB+1:TDPWM_DLO_LSB]} : duty_buf_r;
    // Duty at or above period never clears
    assign full_on = (duty_buf_r[9:2] >= period_value);
    assign raw_nxt = !enable ? 1'b0 :
                     period_start ? (duty_nxt != 10'h000) :
                     (time_base == duty_buf_r && !full_on) ? 1'b0 :
                     raw_r;
    assign level = raw_r ^ polarity;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            duty_buf_r <= 10'h000;
            raw_r <= 1'b0;
        end
        else if (ce)
        begin
            duty_buf_r <= duty_nxt;
            raw_r <= raw_nxt;
        end
    end
endmodule : tdpwm_channel

// file: tdpwm_top.sv
// Operation
// - Clearing output enable releases the modulator pin.
// - Each modulator has 10-bit duty resolution.
// - All modulators share one period; duty values are independent.
// - No postscaler affects modulator timing; only prescaler and period.
// - Outputs go active when the timer count clears.
// - Output clears when time base equals 10-bit duty value.
// - Duty at or above period value keeps output always active.
// - Duty registers double-buffered, reloaded on period match.
// - Polarity bit inverts the modulator output.
// - Period is (period+1) times four oscillator periods times prescale.
// - After count equals period: clear timer, go active, reload duty.
// - Zero duty keeps output inactive at period start.
// - Duty registers writable at any time, even while running.
// - Pulse width is duty times oscillator period times prescale.
// - Duty ratio is duty over four times period plus one.
// - Time base is timer count extended by two prescaled low bits.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tdpwm_top
    import tdpwm_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Modulator pins
    output logic [3:0] MODULATOR_OUTPUT_PIN_O,
    output logic [3:0] MODULATOR_OUTPUT_PIN_OE
);
    localparam int N = TDPWM_NUM_MOD;

    logic [7:0] period_register_r;
    logic [7:0] tctrl_r;
    logic [7:0] period_timer_count_r;
    logic [7:0] period_timer_count_nxt;
    logic [1:0] quarter_r;
    logic [1:0] quarter_nxt;
    logic [7:0] modulator_control_register_r [N];
    logic [7:0] duty_high_register_r [N];
    logic [7:0] duty_low_register_r [N];
    logic [N-1:0] level;
    logic [N-1:0] pin_o_r;
    logic [N-1:0] pin_oe_r;
    logic timer_on;
    logic pre_tick;
    logic quarter_wrap;
    logic period_match;
    logic period_start;
    logic [9:0] time_base;

    // Bus state
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    tdpwm_bus_t wr_state_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [7:0] wbyte;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == TDPWM_OFS_PERIOD) || (a == TDPWM_OFS_TCTRL) || (a == TDPWM_OFS_COUNT) ||
                   ((a >= TDPWM_OFS_MOD_BASE) && (a < TDPWM_OFS_MOD_BASE + 8'(N * 16)) &&
                    (a[3:0] <= TDPWM_OFS_DUTY_LO[3:0]) && (a[1:0] == 2'h0));
    endfunction : addr_hit

    function automatic logic is_mod_reg(input logic [7:0] a, input int idx, input logic [7:0] ofs);
        is_mod_reg = (a == TDPWM_OFS_MOD_BASE + 8'(idx * 16) + ofs);
    endfunction : is_mod_reg

    // Time base: prescaled quarter counter below the 8-bit count
    assign timer_on = tctrl_r[TDPWM_TCTRL_ON];
    assign quarter_wrap = pre_tick && (quarter_r == TDPWM_QUARTER_LAST);
    // One shared period for every modulator
    assign period_match = quarter_wrap && (period_timer_count_r == period_register_r);
    assign quarter_nxt = pre_tick ? quarter_r + 2'h1 : quarter_r;
    // Clear on the increment after the match
    assign period_timer_count_nxt = period_match ? 8'h00 :
                                    quarter_wrap ? period_timer_count_r + 8'h01 : period_timer_count_r;
    assign period_start = period_match;
    // Channels see the coming count so a pin falls as the base reaches duty, at any prescale
    assign time_base = {period_timer_count_nxt, quarter_nxt};

    tdpwm_prescaler u_pre (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .run(timer_on),
        .ratio(tctrl_r[1:0]),
        .tick(pre_tick)
    );

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mod
            tdpwm_channel u_ch (
                .clk(CLK_SYS),
                .srst(SRST),
                .ce(CE),
                .enable(modulator_control_register_r[g][TDPWM_CTRL_EN]),
                .polarity(modulator_control_register_r[g][TDPWM_CTRL_POL]),
                .period_start(period_start),
                .reload(period_match),
                .time_base(time_base),
                .period_value(period_register_r),
                .duty_hi(duty_high_register_r[g]),
                .duty_lo(duty_low_register_r[g]),
                .level(level[g])
            );
        end
    endgenerate

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            period_timer_count_r <= 8'h00;
            quarter_r <= 2'h0;
        end
        else if (CE)
        begin
            period_timer_count_r <= period_timer_count_nxt;
            quarter_r <= quarter_nxt;
        end
    end

    // Pins: released when output enable is clear
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            pin_o_r <= '0;
            pin_oe_r <= '0;
        end
        else if (CE)
        begin
            for (int i = 0; i < N; i++)
            begin
                pin_oe_r[i] <= modulator_control_register_r[i][TDPWM_CTRL_OE];
                pin_o_r[i] <= modulator_control_register_r[i][TDPWM_CTRL_OE] & level[i];
            end
        end
    end

    // Write path: address and data taken independently, response after both
    assign wr_fire = aw_got_r && w_got_r && (wr_state_r == TDPWM_BUS_IDLE);
    assign wr_hit = addr_hit(aw_addr_r);
    assign wbyte = w_strb_r[0] ? w_data_r[7:0] : TDPWM_BYTE_RST;

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            wr_state_r <= TDPWM_BUS_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= TDPWM_RESP_OKAY;
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID && !aw_got_r)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_got_r)
            begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            case (wr_state_r)
                TDPWM_BUS_IDLE:
                    if (wr_fire)
                    begin
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_hit ? TDPWM_RESP_OKAY : TDPWM_RESP_SLVERR;
                        wr_state_r <= TDPWM_BUS_RESP;
                    end
                TDPWM_BUS_RESP:
                    if (S_AXI_BREADY)
                    begin
                        bvalid_r <= 1'b0;
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        wr_state_r <= TDPWM_BUS_IDLE;
                    end
                default:
                    wr_state_r <= TDPWM_BUS_IDLE;
            endcase
        end
    end

    // Register writes; only byte lane 0 holds data
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            period_register_r <= TDPWM_PERIOD_RST;
            tctrl_r <= TDPWM_BYTE_RST;
            for (int i = 0; i < N; i++)
            begin
                modulator_control_register_r[i] <= TDPWM_BYTE_RST;
                duty_high_register_r[i] <= TDPWM_BYTE_RST;
                duty_low_register_r[i] <= TDPWM_BYTE_RST;
            end
        end
        else if (CE && wr_fire && w_strb_r[0])
        begin
            if (aw_addr_r == TDPWM_OFS_PERIOD)
                period_register_r <= wbyte;
            if (aw_addr_r == TDPWM_OFS_TCTRL)
                tctrl_r <= {5'h00, wbyte[2:0]};
            for (int i = 0; i < N; i++)
            begin
                if (is_mod_reg(aw_addr_r, i, TDPWM_OFS_CTRL))
                    modulator_control_register_r[i] <= {wbyte[7:6], 1'b0, wbyte[4], 4'h0};
                // Duty writes accepted any time; buffers isolate the running compare
                if (is_mod_reg(aw_addr_r, i, TDPWM_OFS_DUTY_HI))
                    duty_high_register_r[i] <= wbyte;
                if (is_mod_reg(aw_addr_r, i, TDPWM_OFS_DUTY_LO))
                    duty_low_register_r[i] <= {wbyte[7:6], 6'h00};
            end
        end
    end

    // Read path
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (S_AXI_ARADDR == TDPWM_OFS_PERIOD)
            rd_word = {24'h000000, period_register_r};
        if (S_AXI_ARADDR == TDPWM_OFS_TCTRL)
            rd_word = {24'h000000, tctrl_r};
        if (S_AXI_ARADDR == TDPWM_OFS_COUNT)
            rd_word = {24'h000000, period_timer_count_r};
        for (int i = 0; i < N; i++)
        begin
            if (is_mod_reg(S_AXI_ARADDR, i, TDPWM_OFS_CTRL))
                rd_word = {24'h000000, modulator_control_register_r[i][7:6], level[i],
                           modulator_control_register_r[i][4], 4'h0};
            if (is_mod_reg(S_AXI_ARADDR, i, TDPWM_OFS_DUTY_HI))
                rd_word = {24'h000000, duty_high_register_r[i]};
            if (is_mod_reg(S_AXI_ARADDR, i, TDPWM_OFS_DUTY_LO))
                rd_word = {24'h000000, duty_low_register_r[i]};
        end
    end
    assign rd_hit = addr_hit(S_AXI_ARADDR);

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= TDPWM_RESP_OKAY;
        end
        else if (CE)
        begin
            if (rvalid_r && S_AXI_RREADY)
                rvalid_r <= 1'b0;
            else if (!rvalid_r && S_AXI_ARVALID)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_hit ? TDPWM_RESP_OKAY : TDPWM_RESP_SLVERR;
            end
        end
    end

    assign S_AXI_AWREADY = !aw_got_r && CE && !SRST;
    assign S_AXI_WREADY = !w_got_r && CE && !SRST;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = !rvalid_r && CE && !SRST;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign MODULATOR_OUTPUT_PIN_O = pin_o_r;
    assign MODULATOR_OUTPUT_PIN_OE = pin_oe_r;
endmodule : tdpwm_top

// file: tdpwm_checker.sv
`timescale 1ns/1ps
module tdpwm_checker
    import tdpwm_pkg::*;
(
    // Clock and control
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    // Register bus
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Modulator pins
    input wire logic [3:0] MODULATOR_OUTPUT_PIN_O,
    input wire logic [3:0] MODULATOR_OUTPUT_PIN_OE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    chk_pin_gated: assert property ((MODULATOR_OUTPUT_PIN_O & ~MODULATOR_OUTPUT_PIN_OE) == 4'h0)
        else $error("pin high with output enable off");
    chk_ce_freeze: assert property (!CE |=> $stable(MODULATOR_OUTPUT_PIN_O) && $stable(MODULATOR_OUTPUT_PIN_OE))
        else $error("pins moved while clock enable low");
    chk_ce_ready: assert property (!CE |-> !(S_AXI_AWREADY || S_AXI_WREADY || S_AXI_ARREADY))
        else $error("ready high while clock enable low");
    chk_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    chk_rd_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY && S_AXI_RDATA[31:8] == 24'h000000)
        else $error("second read accepted or wide data");
    chk_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID ##1 !S_AXI_BVALID)
        else $error("write response repeated");
endmodule : tdpwm_checker

// file: tdpwm_tb.sv
`timescale 1ns/1ps
module testbench
    import tdpwm_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, r;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic awr, wrdy, bv, arr, rv, p0;
    logic [1:0] bresp, rresp;
    logic [3:0] po, poe;
    logic [9:0] d;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    logic [15:0] hi_q[$], per_q[$];
    logic [15:0] cp = 16'h0000, ch = 16'h0000;
    int bad_count = 0, checked = 0, cyc = 0;
    integer seed;
    logic [7:0] dh[4] = '{8'h05, 8'h00, 8'h09, 8'h01};
    logic [7:0] dl[4] = '{8'h00, 8'h00, 8'h00, 8'hC0};
    logic [7:0] ctl[4] = '{8'hC0, 8'hC0, 8'hC0, 8'hD0};
    logic [15:0] frac[4] = '{16'h0014, 16'h0000, 16'h0028, 16'h0021};

    always #2.5 clk = ~clk;

    tdpwm_top u_dut (
        .CLK_SYS(clk), .SRST(srst), .CE(ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .MODULATOR_OUTPUT_PIN_O(po), .MODULATOR_OUTPUT_PIN_OE(poe)
    );

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_bus

    task automatic cmp_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_pin

    function automatic logic [33:0] okv(input logic [7:0] v);
        return {TDPWM_RESP_OKAY, 24'h000000, v};
    endfunction : okv

    function automatic logic [7:0] ma(input int i, input logic [7:0] o);
        return TDPWM_OFS_MOD_BASE + 8'(i) * TDPWM_OFS_MOD_STRIDE + o;
    endfunction : ma

    // Random ready stall exercises held responses
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
        b_q.push_back(e);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wrdy));
        repeat ($random(seed) & 3) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bv);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        repeat ($random(seed) & 3) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rv);
        rready <= 1'b0;
    endtask : rd

    // Pushes land after the monitor has seen the rise
    task automatic sync();
        @(posedge po[0]);
        repeat (2) @(posedge clk);
    endtask : sync

    task automatic cnt(input int i, input int len, input logic [15:0] e);
        logic [15:0] n;
        n = 16'h0000;
        repeat (len)
        begin
            @(posedge clk);
            n = n + 16'(po[i]);
        end
        cmp_pin("pin high count", e, n);
    endtask : cnt

    always @(posedge clk)
    begin
        if (!srst && rv && rready && rd_q.size() > 0)
            cmp_bus("read", rd_q.pop_front(), {rresp, rdata});
        if (!srst && bv && bready && b_q.size() > 0)
            cmp_bus("write resp", {32'h00000000, b_q.pop_front()}, {32'h00000000, bresp});
        if (po[0] && !p0)
        begin
            if (per_q.size() > 0)
            begin
                cmp_pin("period", per_q.pop_front(), cp);
                cmp_pin("pulse", hi_q.pop_front(), ch);
            end
            cp = 16'h0001;
            ch = 16'h0001;
        end
        else
        begin
            cp = cp + 16'h0001;
            ch = ch + 16'(po[0]);
        end
        p0 = po[0];
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        seed = 32'hC1B06AA3;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(TDPWM_OFS_PERIOD, okv(TDPWM_PERIOD_RST));
        rd(TDPWM_OFS_TCTRL, okv(TDPWM_BYTE_RST));
        rd(8'h0C, {TDPWM_RESP_SLVERR, 32'h00000000});
        wr(8'h0C, 8'h5A, TDPWM_RESP_SLVERR);
        wr(TDPWM_OFS_PERIOD, 8'h09, TDPWM_RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            r = 8'($random(seed)) & 8'h3F;
            wr(ma(i, TDPWM_OFS_DUTY_HI), dh[i], TDPWM_RESP_OKAY);
            wr(ma(i, TDPWM_OFS_DUTY_LO), dl[i] | r, TDPWM_RESP_OKAY);
            wr(ma(i, TDPWM_OFS_CTRL), ctl[i], TDPWM_RESP_OKAY);
            rd(ma(i, TDPWM_OFS_DUTY_LO), okv(dl[i]));
        end
        wr(TDPWM_OFS_TCTRL, 8'h04, TDPWM_RESP_OKAY);
        sync();
        sync();
        for (int i = 0; i < 4; i++) cnt(i, 40, frac[i]);
        for (int s = 0; s < 4; s++)
        begin
            wr(TDPWM_OFS_TCTRL, 8'h04 | 8'(s), TDPWM_RESP_OKAY);
            sync();
            sync();
            per_q.push_back(16'h0028 << (2 * s));
            hi_q.push_back(16'h0014 << (2 * s));
            sync();
        end
        wr(TDPWM_OFS_TCTRL, 8'h04, TDPWM_RESP_OKAY);
        sync();
        sync();
        wr(ma(0, TDPWM_OFS_DUTY_HI), 8'h03, TDPWM_RESP_OKAY);
        per_q.push_back(16'h0028);
        hi_q.push_back(16'h0014);
        sync();
        per_q.push_back(16'h0028);
        hi_q.push_back(16'h000C);
        sync();
        repeat (3)
        begin
            d = 10'($random(seed) & 32'h1F) + 10'h001;
            wr(ma(0, TDPWM_OFS_DUTY_HI), d[9:2], TDPWM_RESP_OKAY);
            wr(ma(0, TDPWM_OFS_DUTY_LO), {d[1:0], 6'h00}, TDPWM_RESP_OKAY);
            sync();
            sync();
            cnt(0, 40, {6'h00, d});
        end
        wr(ma(2, TDPWM_OFS_CTRL), 8'h80, TDPWM_RESP_OKAY);
        cnt(2, 40, 16'h0000);
        cmp_pin("pin enable", 16'h0000, {15'h0000, poe[2]});
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        rd(TDPWM_OFS_PERIOD, okv(8'h09));
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(ma(0, TDPWM_OFS_CTRL), okv(TDPWM_BYTE_RST));
        end_of_test();
    end
endmodule : testbench

bind tdpwm_top tdpwm_checker u_chk (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .MODULATOR_OUTPUT_PIN_O(MODULATOR_OUTPUT_PIN_O), .MODULATOR_OUTPUT_PIN_OE(MODULATOR_OUTPUT_PIN_OE)
);
